/* occ_channel.sv */
// Output compare channel with Wishbone register access
//
// The register offsets and the Wishbone register port are this design's own decisions.
`include "occ_defs.svh"
`default_nettype none

// What this block does
// - Timebase tick chosen by 3-bit select among peripheral clock, trigger, five timers.
// - Idle-halt bit 13 set stops the channel while the processor idles.
// - Fault B pin is watched only when enable bit 8 is set.
// - Fault A pin is watched only when enable bit 7 is set.
// - Status bit 5 is set by a PWM fault on fault B pin.
// - Status bit 4 is set by a PWM fault on fault A pin.
// - Trigger-clear bit 3 lets secondary match clear the running flag too.
// - Centre PWM: high on primary match, low on secondary match.
// - Edge PWM: high when timer is zero, low on primary match.
// - Mode 101 starts low, toggles forever on alternate primary/secondary matches.
// - Mode 100 starts low, toggles on primary then secondary, one pulse.
// - Mode 011 toggles the pin on every primary match.
// - Mode 010 starts high, goes low at first primary match.
// - Mode 001 starts low, goes high at first primary match.
// - Mode 000 disables the channel.
// - Compare values double-buffered only in PWM modes, direct otherwise.
// - Primary matches raise an interrupt request and a DMA request; secondary matches raise only an interrupt, in modes 100 and up.
// - Timer compared with one or two values, pin changes on matches.
// - Running flag reads one while triggered and counting, zero while held.
// - Trigger/sync select: one triggers the timer, zero synchronises it.
module occ_channel #(
	parameter int WIDTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic cpu_idle_i,
	input wire logic timer1_clock_i,
	input wire logic timer2_clock_i,
	input wire logic timer3_clock_i,
	input wire logic timer4_clock_i,
	input wire logic timer5_clock_i,
	input wire logic trigger_generator_output_i,
	input wire logic sync_trigger_i,
	input wire logic fault_a_pin_i,
	input wire logic fault_b_pin_i,
	output logic compare_output_pin_o,
	output logic match_irq_o,
	output logic match_dma_o
);
	import occ_pkg::*;

	occ_state_s s;
	occ_state_s n;

	// Picks the tick pulse that advances the channel timer
	function automatic logic pick_tick(input logic [2:0] sel, input logic [5:0] t);
		logic r;
		r = 1'b0;
		case (sel)
			`OCC_T_PERIPH: r = 1'b1;
			`OCC_T_TRGGEN: r = t[5];
			`OCC_T_TMR1: r = t[0];
			`OCC_T_TMR5: r = t[4];
			`OCC_T_TMR4: r = t[3];
			`OCC_T_TMR3: r = t[2];
			`OCC_T_TMR2: r = t[1];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// Merges write data into a 16-bit register under the low byte enables
	function automatic occ_word_t merge16(input occ_word_t old, input logic [31:0] d,
		input logic [3:0] be);
		occ_word_t m;
		m = {{8{be[1]}}, {8{be[0]}}};
		return (old & ~m) | (d[15:0] & m);
	endfunction

	// Packs control one for reading
	function automatic occ_word_t pack_ctl1(input occ_state_s x);
		occ_word_t r;
		r = `OCC_CTL1_RST;
		r[`OCC_B_IDLE] = x.idle_halt_select;
		r[`OCC_B_TSEL_HI:`OCC_B_TSEL_LO] = x.timebase_clock_select;
		r[`OCC_B_ENB] = x.fault_b_input_enable;
		r[`OCC_B_ENA] = x.fault_a_input_enable;
		r[`OCC_B_FLTB] = x.fault_b_status;
		r[`OCC_B_FLTA] = x.fault_a_status;
		r[`OCC_B_TRGCLR] = x.trigger_clear_policy;
		r[`OCC_B_MODE_HI:`OCC_B_MODE_LO] = x.compare_mode_select;
		return r;
	endfunction

	// Packs control two for reading
	function automatic occ_word_t pack_ctl2(input occ_state_s x);
		occ_word_t r;
		r = `OCC_CTL2_RST;
		r[`OCC_B_TRGSEL] = x.trigger_or_sync_select;
		r[`OCC_B_RUN] = x.trigger_running_flag;
		r[`OCC_B_WRAP] = x.wrap_on_secondary;
		return r;
	endfunction

	logic hit;
	logic tick;
	logic active;
	logic pwm;
	logic counting;
	logic m_pri;
	logic m_sec;
	logic m_zero;
	logic wrap;
	logic flt_a;
	logic flt_b;
	logic [7:0] adr_word;
	occ_word_t c1;
	occ_word_t c2;

	// Event decode from the present state
	always_comb begin
		hit = wb_cyc_i & wb_stb_i & ~s.ack;
		adr_word = {wb_adr_i[7:2], 2'b00};
		tick = pick_tick(s.timebase_clock_select, {trigger_generator_output_i,
			timer5_clock_i, timer4_clock_i, timer3_clock_i, timer2_clock_i,
			timer1_clock_i}) & ~(cpu_idle_i & s.idle_halt_select);
		active = (s.compare_mode_select != `OCC_M_OFF);
		pwm = (s.compare_mode_select == `OCC_M_EPWM) |
			(s.compare_mode_select == `OCC_M_CPWM);
		counting = active & (~s.trigger_or_sync_select | s.trigger_running_flag);
		m_pri = tick & counting & (s.channel_timer == s.primary_compare_value);
		m_sec = tick & counting & (s.channel_timer == s.secondary_compare_value);
		m_zero = tick & counting & (s.channel_timer == `OCC_TIMER_ZERO);
		wrap = pwm & s.wrap_on_secondary & m_sec;
		flt_a = fault_a_pin_i & s.fault_a_input_enable;
		flt_b = fault_b_pin_i & s.fault_b_input_enable;
	end

	// Next-state logic for the whole channel
	always_comb begin
		n = s;
		n.ack = hit;
		n.irq = 1'b0;
		n.dma = 1'b0;
		c1 = pack_ctl1(s);
		c2 = pack_ctl2(s);

		// Channel timer: held clear, synchronised, wrapped or counted
		if (!active || (s.trigger_or_sync_select && !s.trigger_running_flag)) begin
			n.channel_timer = `OCC_TIMER_ZERO;
		end else if (!s.trigger_or_sync_select && sync_trigger_i) begin
			n.channel_timer = `OCC_TIMER_ZERO;
		end else if (wrap) begin
			n.channel_timer = `OCC_TIMER_ZERO;
		end else if (tick) begin
			n.channel_timer = s.channel_timer + 16'h0001;
		end

		// Shadow values move to the active compare values at the wrap on secondary match
		if (pwm && wrap) begin
			n.primary_compare_value = s.primary_buffer;
			n.secondary_compare_value = s.secondary_buffer;
		end

		// Match requests toward interrupt and DMA logic
		n.irq = m_pri | (m_sec & (s.compare_mode_select >= `OCC_M_DC_SHOT));
		n.dma = m_pri;

		// Pin sequencing per compare mode
		case (s.compare_mode_select)
			`OCC_M_SS_LOW: begin
				if (s.state == OCC_ST_WAIT_PRI && m_pri) begin
					n.pin = 1'b1;
					n.state = OCC_ST_DONE;
				end
			end
			`OCC_M_SS_HIGH: begin
				if (s.state == OCC_ST_WAIT_PRI && m_pri) begin
					n.pin = 1'b0;
					n.state = OCC_ST_DONE;
				end
			end
			`OCC_M_TOGGLE: begin
				if (m_pri) begin
					n.pin = ~s.pin;
				end
			end
			`OCC_M_DC_SHOT: begin
				if (s.state == OCC_ST_WAIT_PRI && m_pri) begin
					n.pin = ~s.pin;
					n.state = OCC_ST_WAIT_SEC;
				end else if (s.state == OCC_ST_WAIT_SEC && m_sec) begin
					n.pin = ~s.pin;
					n.state = OCC_ST_DONE;
				end
			end
			`OCC_M_DC_CONT: begin
				if (s.state == OCC_ST_WAIT_PRI && m_pri) begin
					n.pin = ~s.pin;
					n.state = OCC_ST_WAIT_SEC;
				end else if (s.state == OCC_ST_WAIT_SEC && m_sec) begin
					n.pin = ~s.pin;
					n.state = OCC_ST_WAIT_PRI;
				end
			end
			`OCC_M_EPWM: begin
				if (m_pri) begin
					n.pin = 1'b0;
				end else if (m_zero) begin
					n.pin = 1'b1;
				end
			end
			`OCC_M_CPWM: begin
				if (m_sec) begin
					n.pin = 1'b0;
				end else if (m_pri) begin
					n.pin = 1'b1;
				end
			end
			default: begin
				n.pin = 1'b0;
				n.state = OCC_ST_IDLE;
			end
		endcase

		// Fault holds the PWM pin low until the fault is gone and a period starts
		if (pwm && (flt_a || flt_b)) begin
			n.fault_hold = 1'b1;
		end else if (s.fault_hold && (m_zero || wrap)) begin
			n.fault_hold = 1'b0;
		end
		if (pwm && (flt_a || flt_b || n.fault_hold)) begin
			n.pin = 1'b0;
		end

		// Secondary match may end the triggered run
		if (s.trigger_clear_policy && m_sec) begin
			n.trigger_running_flag = 1'b0;
		end

		// Register writes
		if (hit && wb_we_i) begin
			if (adr_word == `OCC_ADR_CTL1) begin
				c1 = merge16(c1, wb_dat_i, wb_sel_i);
				n.idle_halt_select = c1[`OCC_B_IDLE];
				n.timebase_clock_select = c1[`OCC_B_TSEL_HI:`OCC_B_TSEL_LO];
				n.fault_b_input_enable = c1[`OCC_B_ENB];
				n.fault_a_input_enable = c1[`OCC_B_ENA];
				n.fault_b_status = c1[`OCC_B_FLTB];
				n.fault_a_status = c1[`OCC_B_FLTA];
				n.trigger_clear_policy = c1[`OCC_B_TRGCLR];
				n.compare_mode_select = c1[`OCC_B_MODE_HI:`OCC_B_MODE_LO];
				if (wb_sel_i[0] && n.compare_mode_select != s.compare_mode_select) begin
					n.state = OCC_ST_WAIT_PRI;
					n.pin = (n.compare_mode_select == `OCC_M_SS_HIGH);
					n.fault_hold = 1'b0;
				end
			end else if (adr_word == `OCC_ADR_PRI) begin
				n.primary_buffer = merge16(s.primary_buffer, wb_dat_i, wb_sel_i);
				if (!pwm) begin
					n.primary_compare_value = n.primary_buffer;
				end
			end else if (adr_word == `OCC_ADR_SEC) begin
				n.secondary_buffer = merge16(s.secondary_buffer, wb_dat_i, wb_sel_i);
				if (!pwm) begin
					n.secondary_compare_value = n.secondary_buffer;
				end
			end else if (adr_word == `OCC_ADR_CTL2) begin
				c2 = merge16(c2, wb_dat_i, wb_sel_i);
				n.trigger_or_sync_select = c2[`OCC_B_TRGSEL];
				n.trigger_running_flag = c2[`OCC_B_RUN];
				n.wrap_on_secondary = c2[`OCC_B_WRAP];
			end
		end

		// Hardware sets win over software clears in the same cycle
		if (pwm && flt_a) begin
			n.fault_a_status = 1'b1;
		end
		if (pwm && flt_b) begin
			n.fault_b_status = 1'b1;
		end
		if (active && s.trigger_or_sync_select && sync_trigger_i) begin
			n.trigger_running_flag = 1'b1;
		end

		// Read data, zero for unmapped addresses and for writes
		n.dat = 32'h0000_0000;
		if (hit && !wb_we_i) begin
			if (adr_word == `OCC_ADR_CTL1) begin
				n.dat = {16'h0000, pack_ctl1(s)};
			end else if (adr_word == `OCC_ADR_PRI) begin
				n.dat = {16'h0000, s.primary_buffer};
			end else if (adr_word == `OCC_ADR_SEC) begin
				n.dat = {16'h0000, s.secondary_buffer};
			end else if (adr_word == `OCC_ADR_CTL2) begin
				n.dat = {16'h0000, pack_ctl2(s)};
			end else if (adr_word == `OCC_ADR_TMR) begin
				n.dat = {16'h0000, s.channel_timer};
			end
		end
	end

	// State register, cleared by synchronous reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	// Outputs straight from flip-flops
	assign wb_dat_o = s.dat;
	assign wb_ack_o = s.ack;
	assign compare_output_pin_o = s.pin;
	assign match_irq_o = s.irq;
	assign match_dma_o = s.dma;

endmodule
`default_nettype wire

/* occ_channel_chk.sv */
// Port assertions for the output compare channel
`default_nettype none
module occ_channel_chk (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic fault_a_pin_i,
	input wire logic compare_output_pin_o,
	input wire logic match_irq_o,
	input wire logic match_dma_o
);
	logic [2:0] mode;
	logic ena;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Shadow of mode and fault A enable, taken where a control write is taken
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode <= 3'h0;
			ena <= 1'b0;
		end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h00
			&& wb_sel_i[0]) begin
			mode <= wb_dat_i[2:0];
			ena <= wb_dat_i[7];
		end
	end
	sequence s_take;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_quiet;
		$stable(mode) && !wb_ack_o;
	endsequence
	bus_ack_a: assert property (s_take |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle after request");
	idle_dat_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
		else $error("read data outside ack");
	off_quiet_a: assert property ((mode == 3'h0 and s_quiet)
		|-> !(compare_output_pin_o || match_irq_o || match_dma_o))
		else $error("disabled channel active");
	toggle_a: assert property ((mode == 3'h3 and s_quiet)
		|-> $changed(compare_output_pin_o) == match_dma_o)
		else $error("toggle not tied to primary match");
	ss_low_a: assert property ((mode == 3'h1 and s_quiet)
		|-> !$fell(compare_output_pin_o) && (!$rose(compare_output_pin_o) || match_dma_o))
		else $error("single shot high misbehaves");
	ss_high_a: assert property ((mode == 3'h2 and s_quiet)
		|-> !$rose(compare_output_pin_o) && (!$fell(compare_output_pin_o) || match_dma_o))
		else $error("single shot low misbehaves");
	dma_irq_a: assert property (match_dma_o |-> match_irq_o)
		else $error("primary match without interrupt");
	irq_only_a: assert property (mode inside {3'h1, 3'h2, 3'h3}
		|-> match_irq_o == match_dma_o)
		else $error("secondary interrupt in single mode");
	fault_low_a: assert property (mode[2:1] == 2'b11 && ena && fault_a_pin_i
		&& !wb_ack_o |=> ##[0:1] !compare_output_pin_o)
		else $error("fault did not force pin low");
	reset_out_a: assert property (disable iff (1'b0) rst_i |=> !compare_output_pin_o && !wb_ack_o)
		else $error("outputs active after reset");
endmodule
`default_nettype wire

/* occ_channel_tb.sv */
// Self-checking bench for the output compare channel
`default_nettype none
module occ_channel_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, idle = 1'b0, clr = 1'b0, run = 1'b0;
	logic sync = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0000_0000, rdat, dat_o, v;
	logic [31:0] rs = 32'd14512, tr = 32'd14512;
	logic [5:0] tick = 6'h00;
	logic [1:0] flt = 2'b00;
	logic [7:0] ad [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
	int map [6] = '{1, 2, 3, 4, 0, 5};
	logic ack, pin, irq, dma, fa, fb;
	int high, err_total = 0, n_checks = 0, cnt = 0, tsel = 7, p, s;
	always #20 clk_i = ~clk_i;
	occ_channel i_dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.cpu_idle_i(idle), .timer1_clock_i(tick[0]), .timer2_clock_i(tick[1]),
		.timer3_clock_i(tick[2]), .timer4_clock_i(tick[3]), .timer5_clock_i(tick[4]),
		.trigger_generator_output_i(tick[5]), .sync_trigger_i(sync), .fault_a_pin_i(fa),
		.fault_b_pin_i(fb), .compare_output_pin_o(pin), .match_irq_o(irq), .match_dma_o(dma));
	occ_load i_load (.clk_i, .pin_i(pin), .clr_i(clr), .flt_cmd_i(flt), .fault_a_o(fa),
		.fault_b_o(fb), .high_o(high));
	function automatic logic [31:0] xs(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic logic [31:0] nxt();
		rs = xs(rs);
		return rs;
	endfunction
	function automatic int exp_high(int m, int p, int s);
		case (m)
			1, 3: return 149 - p;
			2: return p + 1;
			6: return p;
			default: return s - p;
		endcase
	endfunction
	// Random timer ticks inside a window, tallying the selected source
	always @(posedge clk_i) begin
		if (tsel < 6) cnt += int'(tick[map[tsel]]);
		tr = xs(tr);
		tick <= run ? tr[5:0] : 6'h00;
	end
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Cut a hang short
	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		end_of_test();
	end
	// Main sequence
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b1, 8'h14, 32'h0000_FFFF);
		foreach (ad[i]) begin
			wb(1'b0, ad[i], 32'h0000_0000);
			chk("reset", rdat, 32'h0000_0000);
		end
		$display("reset values done");
		repeat (4) begin
			v = nxt() & 32'h0000_3D88;
			wb(1'b1, 8'h00, v | 32'hFFFF_C240);
			wb(1'b0, 8'h00, 32'h0000_0000);
			chk("control", rdat, v);
		end
		$display("control access done");
		for (int m = 1; m < 8; m++) begin
			p = 10 + int'(nxt() % 40);
			s = p + 5 + int'(nxt() % 40);
			wb(1'b1, 8'h00, 32'h0000_0000);
			wb(1'b1, 8'h04, 32'(p));
			wb(1'b1, 8'h08, 32'(s));
			clr <= 1'b1;
			@(posedge clk_i);
			clr <= 1'b0;
			wb(1'b1, 8'h00, 32'h0000_1C00 | 32'(m));
			repeat (150) @(posedge clk_i);
			chk("high", 32'(high), 32'(exp_high(m, p, s)));
			chk("pin", {31'h0, pin}, {31'h0, m == 1 || m == 3});
		end
		$display("compare modes done");
		wb(1'b1, 8'h00, 32'h0000_0000);
		wb(1'b1, 8'h00, 32'h0000_1C87);
		repeat (p + 2) @(posedge clk_i);
		chk("pwm high", {31'h0, pin}, 32'h0000_0001);
		flt <= 2'b11;
		repeat (3) @(posedge clk_i);
		chk("fault pin", {31'h0, pin}, 32'h0000_0000);
		flt <= 2'b00;
		wb(1'b0, 8'h00, 32'h0000_0000);
		chk("fault a", rdat, 32'h0000_1C97);
		wb(1'b1, 8'h00, 32'h0000_1D07);
		flt <= 2'b10;
		repeat (3) @(posedge clk_i);
		flt <= 2'b00;
		wb(1'b0, 8'h00, 32'h0000_0000);
		chk("fault b", rdat, 32'h0000_1D27);
		$display("faults done");
		// Edge PWM with wrap on secondary: a new primary lands only at the wrap
		wb(1'b1, 8'h00, 32'h0000_0000);
		wb(1'b1, 8'h04, 32'h0000_0004);
		wb(1'b1, 8'h08, 32'h0000_0009);
		wb(1'b1, 8'h0C, 32'h0000_0001);
		clr <= 1'b1;
		@(posedge clk_i);
		clr <= 1'b0;
		wb(1'b1, 8'h00, 32'h0000_1C06);
		wb(1'b1, 8'h04, 32'h0000_0007);
		repeat (17) @(posedge clk_i);
		chk("buffered", 32'(high), 32'd11);
		$display("double buffer done");
		wb(1'b1, 8'h00, 32'h0000_0000);
		idle <= 1'b1;
		wb(1'b1, 8'h04, 32'h0000_FFFF);
		wb(1'b1, 8'h00, 32'h0000_3C03);
		repeat (20) @(posedge clk_i);
		wb(1'b0, 8'h10, 32'h0000_0000);
		chk("halted", rdat, 32'h0000_0000);
		wb(1'b1, 8'h00, 32'h0000_1C03);
		repeat (20) @(posedge clk_i);
		wb(1'b0, 8'h10, 32'h0000_0000);
		chk("idle run", rdat, 32'd22);
		idle <= 1'b0;
		$display("idle halt done");
		for (int t = 0; t < 8; t++) begin
			wb(1'b1, 8'h00, 32'h0000_0000);
			wb(1'b1, 8'h00, 32'(t << 10) | 32'h0000_0003);
			tsel = t;
			cnt = 0;
			run <= 1'b1;
			repeat (30) @(posedge clk_i);
			run <= 1'b0;
			wb(1'b0, 8'h10, 32'h0000_0000);
			chk("ticks", rdat, t == 7 ? 32'd32 : t == 6 ? 32'd0 : 32'(cnt));
		end
		tsel = 7;
		$display("clock select done");
		wb(1'b1, 8'h00, 32'h0000_0000);
		wb(1'b1, 8'h0C, 32'h0000_0080);
		wb(1'b1, 8'h08, 32'h0000_0005);
		wb(1'b1, 8'h00, 32'h0000_1C0B);
		repeat (10) @(posedge clk_i);
		wb(1'b0, 8'h10, 32'h0000_0000);
		chk("held", rdat, 32'h0000_0000);
		sync <= 1'b1;
		@(posedge clk_i);
		sync <= 1'b0;
		repeat (20) @(posedge clk_i);
		wb(1'b0, 8'h0C, 32'h0000_0000);
		chk("flag clr", rdat, 32'h0000_0080);
		wb(1'b1, 8'h00, 32'h0000_1C03);
		wb(1'b1, 8'h0C, 32'h0000_00C0);
		repeat (20) @(posedge clk_i);
		wb(1'b0, 8'h0C, 32'h0000_0000);
		chk("flag kept", rdat, 32'h0000_00C0);
		wb(1'b1, 8'h0C, 32'h0000_0000);
		sync <= 1'b1;
		@(posedge clk_i);
		sync <= 1'b0;
		repeat (10) @(posedge clk_i);
		wb(1'b0, 8'h10, 32'h0000_0000);
		chk("synced", rdat, 32'd11);
		$display("trigger done");
		end_of_test();
	end
endmodule
bind occ_channel occ_channel_chk i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .fault_a_pin_i,
	.compare_output_pin_o, .match_irq_o, .match_dma_o);
`default_nettype wire

/* occ_defs.svh */
// Constant names for the output compare channel: offsets, bit positions, codes
`ifndef OCC_DEFS_SVH
`define OCC_DEFS_SVH

// Register byte addresses
`define OCC_ADR_CTL1 8'h00
`define OCC_ADR_PRI 8'h04
`define OCC_ADR_SEC 8'h08
`define OCC_ADR_CTL2 8'h0C
`define OCC_ADR_TMR 8'h10

// Control one field positions
`define OCC_B_IDLE 13
`define OCC_B_TSEL_HI 12
`define OCC_B_TSEL_LO 10
`define OCC_B_ENB 8
`define OCC_B_ENA 7
`define OCC_B_FLTB 5
`define OCC_B_FLTA 4
`define OCC_B_TRGCLR 3
`define OCC_B_MODE_HI 2
`define OCC_B_MODE_LO 0

// Control two field positions
`define OCC_B_TRGSEL 7
`define OCC_B_RUN 6
`define OCC_B_WRAP 0

// Compare mode codes
`define OCC_M_OFF 3'h0
`define OCC_M_SS_LOW 3'h1
`define OCC_M_SS_HIGH 3'h2
`define OCC_M_TOGGLE 3'h3
`define OCC_M_DC_SHOT 3'h4
`define OCC_M_DC_CONT 3'h5
`define OCC_M_EPWM 3'h6
`define OCC_M_CPWM 3'h7

// Timebase clock select codes
`define OCC_T_TMR2 3'h0
`define OCC_T_TMR3 3'h1
`define OCC_T_TMR4 3'h2
`define OCC_T_TMR5 3'h3
`define OCC_T_TMR1 3'h4
`define OCC_T_TRGGEN 3'h5
`define OCC_T_RSVD 3'h6
`define OCC_T_PERIPH 3'h7

// Reset values
`define OCC_CTL1_RST 16'h0000
`define OCC_CTL2_RST 16'h0000
`define OCC_TIMER_ZERO 16'h0000

`endif

/* occ_load.sv */
// Load model standing on the compare output and the two fault pins
`default_nettype none
module occ_load (
	input wire logic clk_i,
	input wire logic pin_i,
	input wire logic clr_i,
	input wire logic [1:0] flt_cmd_i,
	output logic fault_a_o,
	output logic fault_b_o,
	output int high_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// Fault sensors report the commanded condition, active high
	assign fault_a_o = flt_cmd_i[0];
	assign fault_b_o = flt_cmd_i[1];
	// Count the cycles in which the load is energised
	always_ff @(posedge clk_i) begin
		if (clr_i)
			high_o <= 0;
		else if (pin_i)
			high_o <= high_o + 1;
	end
endmodule
`default_nettype wire

/* occ_pkg.sv */
// Types shared by the output compare channel
`default_nettype none
package occ_pkg;

	// Output sequencing state, Gray coded along idle, primary, secondary, done
	typedef enum logic [1:0] {
		OCC_ST_IDLE = 2'b00,
		OCC_ST_WAIT_PRI = 2'b01,
		OCC_ST_WAIT_SEC = 2'b11,
		OCC_ST_DONE = 2'b10
	} occ_state_e;

	typedef logic [15:0] occ_word_t;

	// Whole state of the channel
	typedef struct packed {
		logic idle_halt_select;
		logic [2:0] timebase_clock_select;
		logic fault_b_input_enable;
		logic fault_a_input_enable;
		logic fault_b_status;
		logic fault_a_status;
		logic trigger_clear_policy;
		logic [2:0] compare_mode_select;
		logic trigger_or_sync_select;
		logic trigger_running_flag;
		logic wrap_on_secondary;
		occ_word_t primary_compare_value;
		occ_word_t secondary_compare_value;
		occ_word_t primary_buffer;
		occ_word_t secondary_buffer;
		occ_word_t channel_timer;
		logic fault_hold;
		logic pin;
		occ_state_e state;
		logic ack;
		logic [31:0] dat;
		logic irq;
		logic dma;
	} occ_state_s;

endpackage
`default_nettype wire
